// [include/hwcall_consts.svh]
`ifndef HWCALL_CONSTS_SVH
`define HWCALL_CONSTS_SVH

// Command codes written by the caller
`define CODE_FILL 16'h5212
`define CODE_COPY 16'h5104

// Result word layout
`define RES_DONE_BIT 29
`define RES_COPY_BIT 0
`define FILL_OK 2'b00
`define FILL_BAD 2'b01
`define FILL_EXC 2'b10
`define ZERO_WORD 32'h0000_0000

// Fill limits and strides
`define FILL_MIN_WORDS 32'h0000_0004
`define WORD_STEP 32'h0000_0004
`define COUNT_ONE 32'h0000_0001
`define BYTE_ONE_MASK 4'h1
`define BE_ALL 4'hf

// Caller register offsets on APB (byte addresses)
`define OFF_CMD 8'h00
`define OFF_ARG0 8'h04
`define OFF_ARG1 8'h08
`define OFF_ARG2 8'h0c
`define OFF_ARG3 8'h10
`define OFF_RESULT 8'h14
`define OFF_FAULT 8'h18
`define OFF_STATUS 8'h1c

// Status register fields
`define ST_PEND_BIT 0
`define ST_REFUSED_BIT 1
`define ST_IRQ_LSB 8
`define ST_IRQ_MSB 15

`endif

// [include/hwcall_pkg.sv]
package hwcall_pkg;
   // Gray order along idle -> fill, idle -> read <-> write
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FILL = 2'b10,
      ST_CRD = 2'b01,
      ST_CWR = 2'b11
   } engine_state_t;
endpackage : hwcall_pkg

// [include/hwcall_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface hwcall_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [15:0] call_command_code;
   logic [31:0] first_argument_word;
   logic [31:0] second_argument_word;
   logic [31:0] third_argument_word;
   logic [31:0] fourth_argument_word;
   logic [31:0] result_word;
   logic [31:0] fault_address_word;
   logic copy_irq;

   modport engine (
      input cmd_valid, call_command_code, first_argument_word,
      input second_argument_word, third_argument_word,
      input fourth_argument_word,
      output cmd_ready, result_word, fault_address_word, copy_irq
   );
   modport caller (
      output cmd_valid, call_command_code, first_argument_word,
      output second_argument_word, third_argument_word,
      output fourth_argument_word,
      input cmd_ready, result_word, fault_address_word, copy_irq
   );
endinterface : hwcall_if
`default_nettype wire

// [rtl/hwcall_caller.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hwcall_consts.svh"
module hwcall_caller
   import hwcall_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   hwcall_if.caller call
);
   logic [31:0] arg_reg [4];
   logic [15:0] code_reg;
   logic issue_reg;
   logic wait_reg;
   logic refused_reg;
   logic [7:0] irq_count_reg;
   logic wr_en;
   logic cmd_wr;
   logic busy;
   logic mapped;

   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign cmd_wr = wr_en && paddr == `OFF_CMD;
   assign busy = issue_reg || wait_reg;

   always_comb begin
      mapped = 1'b1;
      prdata = `ZERO_WORD;
      unique case (paddr)
         `OFF_CMD: prdata = {16'h0000, code_reg};
         `OFF_ARG0: prdata = arg_reg[0];
         `OFF_ARG1: prdata = arg_reg[1];
         `OFF_ARG2: prdata = arg_reg[2];
         `OFF_ARG3: prdata = arg_reg[3];
         `OFF_RESULT: prdata = call.result_word;
         `OFF_FAULT: prdata = call.fault_address_word;
         `OFF_STATUS: begin
            prdata[`ST_PEND_BIT] = busy;
            prdata[`ST_REFUSED_BIT] = refused_reg;
            prdata[`ST_IRQ_MSB:`ST_IRQ_LSB] = irq_count_reg;
         end
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            arg_reg[i] <= `ZERO_WORD;
         end
      end else if (wr_en && !busy) begin
         if (paddr == `OFF_ARG0) arg_reg[0] <= pwdata;
         if (paddr == `OFF_ARG1) arg_reg[1] <= pwdata;
         if (paddr == `OFF_ARG2) arg_reg[2] <= pwdata;
         if (paddr == `OFF_ARG3) arg_reg[3] <= pwdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         code_reg <= 16'h0000;
         issue_reg <= 1'b0;
      end else if (cmd_wr && !busy) begin
         code_reg <= pwdata[15:0];
         issue_reg <= 1'b1;
      end else if (issue_reg && call.cmd_ready) begin
         issue_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wait_reg <= 1'b0;
      end else if (issue_reg && call.cmd_ready) begin
         wait_reg <= 1'b1;
      end else if (call.result_word[`RES_DONE_BIT]) begin
         wait_reg <= 1'b0;
      end
   end

   // Sticky; a status write clears it, even while busy
   always_ff @(posedge core_clk) begin
      if (reset) begin
         refused_reg <= 1'b0;
      end else if (wr_en && busy && paddr != `OFF_STATUS) begin
         refused_reg <= 1'b1;
      end else if (wr_en && paddr == `OFF_STATUS) begin
         refused_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_count_reg <= 8'h00;
      end else if (call.copy_irq) begin
         irq_count_reg <= irq_count_reg + 8'h01;
      end
   end

   assign call.cmd_valid = issue_reg;
   assign call.call_command_code = code_reg;
   assign call.first_argument_word = arg_reg[0];
   assign call.second_argument_word = arg_reg[1];
   assign call.third_argument_word = arg_reg[2];
   assign call.fourth_argument_word = arg_reg[3];
endmodule : hwcall_caller
`default_nettype wire

// [rtl/hwcall_engine.sv]
// Summary of operation
// - code 5212h starts pattern fill
// - caller supplies pattern, start, word count
// - unaligned start or count under four refused
// - fill result 00b success, 10b exception
// - fault address returned, else zero
// - completion bit 29 set when done
// - code 5104h starts buffer byte copy
// - caller supplies source, destination, 16-bit count
// - interrupt pulse when copy finishes without a fault
// - copy result bit 0, fault word zero
// - fill writes consecutive words from start
`timescale 1ns/1ps
`default_nettype none
`include "hwcall_consts.svh"
module hwcall_engine
   import hwcall_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   hwcall_if.engine call,
   output logic mem_valid,
   output logic mem_write,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [3:0] mem_be,
   input wire logic mem_ready,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_error
);
   engine_state_t state_reg;
   engine_state_t state_next;
   logic [31:0] addr_reg;
   logic [31:0] src_reg;
   logic [31:0] dst_reg;
   logic [31:0] count_reg;
   logic [31:0] data_reg;
   logic [3:0] be_reg;
   logic [31:0] result_reg;
   logic [31:0] result_next;
   logic [31:0] fault_reg;
   logic irq_reg;
   logic accept;
   logic is_fill;
   logic is_copy;
   logic fill_bad;
   logic copy_bad;
   logic copy_empty;
   logic beat;
   logic last;
   logic [7:0] rd_byte;

   assign accept = state_reg == ST_IDLE && call.cmd_valid;
   assign is_fill = call.call_command_code == `CODE_FILL;
   assign is_copy = call.call_command_code == `CODE_COPY;
   assign fill_bad = call.second_argument_word[1:0] != 2'b00
                  || call.third_argument_word < `FILL_MIN_WORDS;
   // nonzero fourth word is an invalid call
   assign copy_bad = call.fourth_argument_word != `ZERO_WORD;
   assign copy_empty = call.third_argument_word[15:0] == 16'h0000;
   assign beat = mem_valid && mem_ready;
   assign last = count_reg == `COUNT_ONE;
   assign rd_byte = mem_rdata[{src_reg[1:0], 3'b000} +: 8];

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (accept && is_fill && !fill_bad) begin
               state_next = ST_FILL;
            end else if (accept && is_copy && !copy_bad && !copy_empty) begin
               state_next = ST_CRD;
            end
         end
         ST_FILL: begin
            if (beat && (mem_error || last)) state_next = ST_IDLE;
         end
         ST_CRD: begin
            if (beat) state_next = mem_error ? ST_IDLE : ST_CWR;
         end
         ST_CWR: begin
            if (beat) state_next = (mem_error || last) ? ST_IDLE : ST_CRD;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         addr_reg <= `ZERO_WORD;
         src_reg <= `ZERO_WORD;
         dst_reg <= `ZERO_WORD;
         count_reg <= `ZERO_WORD;
      end else if (accept && is_fill) begin
         addr_reg <= call.second_argument_word;
         count_reg <= call.third_argument_word;
      end else if (accept) begin
         src_reg <= call.first_argument_word;
         dst_reg <= call.second_argument_word;
         addr_reg <= {call.first_argument_word[31:2], 2'b00};
         count_reg <= {16'h0000, call.third_argument_word[15:0]};
      end else if (beat) begin
         unique case (state_reg)
            ST_FILL: begin
               addr_reg <= addr_reg + `WORD_STEP;
               count_reg <= count_reg - `COUNT_ONE;
            end
            ST_CRD: addr_reg <= {dst_reg[31:2], 2'b00};
            ST_CWR: begin
               addr_reg <= {src_reg[31:2] + 30'd0, 2'b00} + 
                  ((src_reg[1:0] == 2'b11) ? `WORD_STEP : `ZERO_WORD);
               src_reg <= src_reg + `COUNT_ONE;
               dst_reg <= dst_reg + `COUNT_ONE;
               count_reg <= count_reg - `COUNT_ONE;
            end
            ST_IDLE: addr_reg <= addr_reg;
         endcase
      end
   end

   // pattern data; copy carries one byte on all lanes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         data_reg <= `ZERO_WORD;
         be_reg <= `BE_ALL;
      end else if (accept && is_fill) begin
         data_reg <= call.first_argument_word;
         be_reg <= `BE_ALL;
      end else if (beat && state_reg == ST_CRD) begin
         data_reg <= {4{rd_byte}};
         be_reg <= `BYTE_ONE_MASK << dst_reg[1:0];
      end
   end

   always_comb begin
      result_next = result_reg;
      if (accept) begin
         result_next = `ZERO_WORD;
         if (is_fill && fill_bad) begin
            result_next[1:0] = `FILL_BAD;
            result_next[`RES_DONE_BIT] = 1'b1;
         end else if (is_copy && (copy_bad || copy_empty)) begin
            result_next[`RES_COPY_BIT] = copy_bad;
            result_next[`RES_DONE_BIT] = 1'b1;
         end else if (!is_fill && !is_copy) begin
            result_next[`RES_COPY_BIT] = 1'b1;
            result_next[`RES_DONE_BIT] = 1'b1;
         end
      end else if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
         result_next[`RES_DONE_BIT] = 1'b1;
         if (state_reg == ST_FILL) begin
            result_next[1:0] = mem_error ? `FILL_EXC : `FILL_OK;
         end else begin
            // copy fault reported in bit 0
            result_next[`RES_COPY_BIT] = mem_error;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         result_reg <= `ZERO_WORD;
      end else begin
         result_reg <= result_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || accept) begin
         fault_reg <= `ZERO_WORD;
      end else if (beat && mem_error && state_reg == ST_FILL) begin
         fault_reg <= addr_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (accept && is_copy && !copy_bad && copy_empty)
            || (state_reg == ST_CWR && beat && last && !mem_error);
      end
   end

   assign call.cmd_ready = state_reg == ST_IDLE;
   assign call.result_word = result_reg;
   assign call.fault_address_word = fault_reg;
   assign call.copy_irq = irq_reg;
   assign mem_valid = state_reg != ST_IDLE;
   assign mem_write = state_reg == ST_FILL || state_reg == ST_CWR;
   assign mem_addr = addr_reg;
   assign mem_wdata = data_reg;
   assign mem_be = be_reg;
endmodule : hwcall_engine
`default_nettype wire

// [testbench/hwcall_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module hwcall_monitor (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [15:0] call_command_code,
   input wire logic [31:0] second_argument_word,
   input wire logic [31:0] third_argument_word,
   input wire logic [31:0] fourth_argument_word,
   input wire logic [31:0] result_word,
   input wire logic [31:0] fault_address_word,
   input wire logic copy_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic bad_fill = second_argument_word[1:0] != 2'b00 ||
      third_argument_word < 32'h0000_0004;
   sequence fill_s;
      cmd_valid && cmd_ready && call_command_code == 16'h5212;
   endsequence
   sequence copy_s;
      cmd_valid && cmd_ready && call_command_code == 16'h5104;
   endsequence
   fill_start_a: assert property (fill_s ##0 !bad_fill |=>
      !cmd_ready && result_word == 32'h0) else $error("fill not started");
   fill_refuse_a: assert property (fill_s ##0 bad_fill |=>
      result_word == 32'h2000_0001) else $error("bad fill not refused");
   copy_bad_a: assert property (copy_s ##0 fourth_argument_word != 0
      |=> result_word == 32'h2000_0001) else $error("bad copy accepted");
   copy_fault_a: assert property (copy_s |=>
      fault_address_word == 32'h0) else $error("copy fault word set");
   unused_bits_a: assert property (result_word[31:30] == 2'b00 &&
      result_word[28:2] == 27'h0) else $error("unused result bits set");
   ok_fault_a: assert property (result_word[29] &&
      result_word[1:0] == 2'b00 |-> fault_address_word == 32'h0)
      else $error("fault word set on success");
   done_hold_a: assert property (result_word[29] && !cmd_valid |=>
      $stable(result_word) && $stable(fault_address_word))
      else $error("result changed while done");
   irq_pulse_a: assert property (copy_irq |->
      result_word[29] && !result_word[0] ##1 !copy_irq)
      else $error("copy interrupt malformed");
   irq_after_a: assert property ($rose(result_word[29]) &&
      call_command_code == 16'h5104 && !result_word[0] |-> copy_irq)
      else $error("no interrupt after copy");
endmodule : hwcall_monitor
`default_nettype wire

// [testbench/hw_call_fill_and_buffer_copy_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hwcall_consts.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module hw_call_fill_and_buffer_copy_test
   import hwcall_pkg::*;
;
   logic core_clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr, sa, da;
   logic [31:0] pwdata, prdata, r, pat, keep, e, g, mem_addr, mem_wdata;
   logic mem_valid, mem_write, mem_ready, err_on;
   logic [31:0] err_at;
   logic [3:0] mem_be;
   logic [31:0] mem [0:63];
   logic [7:0] b [0:2];
   logic [15:0] lfsr = 16'hdff8;
   logic [15:0] s;
   int n_mismatch = 0, checked = 0, wr_cnt = 0, w;
   string nm, name_q[$];
   logic [31:0] exp_q[$], seen_q[$];
   event seen_ev;
   // Memory answers from the same clock; no synchroniser expected
   wire logic [31:0] mem_rdata = mem[mem_addr[7:2]];
   wire logic mem_error = err_on && mem_addr == err_at;
   hwcall_if call_link();
   hwcall_caller i_hwcall_caller (.core_clk(core_clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .call(call_link.caller));
   hwcall_engine i_hwcall_engine (.core_clk(core_clk), .reset(reset),
      .call(call_link.engine), .mem_valid(mem_valid),
      .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_be(mem_be), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
      .mem_error(mem_error));
   hwcall_monitor i_hwcall_monitor (.core_clk(core_clk), .reset(reset),
      .cmd_valid(call_link.cmd_valid), .cmd_ready(call_link.cmd_ready),
      .call_command_code(call_link.call_command_code),
      .second_argument_word(call_link.second_argument_word),
      .third_argument_word(call_link.third_argument_word),
      .fourth_argument_word(call_link.fourth_argument_word),
      .result_word(call_link.result_word),
      .fault_address_word(call_link.fault_address_word),
      .copy_irq(call_link.copy_irq));
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   // Random stalls on the memory side stretch some beats
   always @(posedge core_clk) begin
      lfsr <= lfsr_next(lfsr);
      mem_ready <= lfsr[0] | lfsr[3];
      if (mem_valid && mem_ready && mem_write && !mem_error) begin
         wr_cnt <= wr_cnt + 1;
         for (int i = 0; i < 4; i++)
            if (mem_be[i]) mem[mem_addr[7:2]][8*i +: 8] <= mem_wdata[8*i +: 8];
      end
   end
   always @(seen_ev) begin
      while (exp_q.size() > 0) begin
         nm = name_q.pop_front();
         e = exp_q.pop_front();
         g = seen_q.pop_front();
         `CHK(nm, e, g)
      end
   end
   task automatic note(input string n, input logic [31:0] x, y);
      name_q.push_back(n);
      exp_q.push_back(x);
      seen_q.push_back(y);
      -> seen_ev;
   endtask : note
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk) penable <= 1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!pready && n < 20);
      r = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
      if (n >= 20) begin
         n_mismatch++;
         results();
      end
   endtask : apb
   task automatic rd(input string n, input logic [7:0] a,
         input logic [31:0] x);
      apb(0, a, 0);
      note(n, x, r);
   endtask : rd
   task automatic call(input logic [15:0] c,
         input logic [31:0] a0, a1, a2, a3);
      apb(1, `OFF_ARG0, a0);
      apb(1, `OFF_ARG1, a1);
      apb(1, `OFF_ARG2, a2);
      apb(1, `OFF_ARG3, a3);
      apb(1, `OFF_CMD, {16'h0, c});
      wait_done();
   endtask : call
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(0, `OFF_RESULT, 0);
         n++;
      end while (!r[29] && n < 100);
      if (n >= 100) begin
         n_mismatch++;
         results();
      end
   endtask : wait_done
   task automatic results();
      #1;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   initial begin
      {psel, penable, pwrite, paddr, pwdata, err_on, err_at, mem_ready} = 0;
      reset = 1;
      s = 16'hdff8;
      for (int i = 0; i < 64; i++) begin
         s = lfsr_next(s);
         mem[i] = {s, ~s};
      end
      repeat (20) @(posedge core_clk);
      reset <= 0;
      @(posedge core_clk);
      pat = {lfsr, ~lfsr};
      keep = mem[20];
      call(`CODE_FILL, pat, 32'h40, 32'h4, 0);
      rd("fill result", `OFF_RESULT, 32'h2000_0000);
      rd("fill fault", `OFF_FAULT, 0);
      for (int i = 16; i < 21; i++) begin
         note("fill word", i < 20 ? pat : keep, mem[i]);
      end
      $display("fill of four words done");
      w = wr_cnt;
      call(`CODE_FILL, pat, 32'h42, 32'h4, 0);
      rd("unaligned", `OFF_RESULT, 32'h2000_0001);
      call(`CODE_FILL, pat, 32'h40, 32'h3, 0);
      rd("short fill", `OFF_RESULT, 32'h2000_0001);
      note("no writes", 32'(w), 32'(wr_cnt));
      $display("fill refusals done");
      err_at <= 32'h88;
      err_on <= 1;
      call(`CODE_FILL, ~pat, 32'h80, 32'h8, 0);
      err_on <= 0;
      rd("exc result", `OFF_RESULT, 32'h2000_0002);
      rd("exc fault", `OFF_FAULT, 32'h88);
      $display("fill exception done");
      for (int k = 0; k < 3; k++) begin
         sa = 8'h81 + k[7:0];
         b[k] = mem[sa[7:2]][8*sa[1:0] +: 8];
      end
      call(`CODE_COPY, 32'h81, 32'hc2, 32'hbeef_0003, 0);
      rd("copy result", `OFF_RESULT, 32'h2000_0000);
      rd("copy fault", `OFF_FAULT, 0);
      for (int k = 0; k < 3; k++) begin
         da = 8'hc2 + k[7:0];
         note("copied byte", {24'h0, b[k]},
            {24'h0, mem[da[7:2]][8*da[1:0] +: 8]});
      end
      apb(0, `OFF_STATUS, 0);
      note("irq count", 32'h1, {24'h0, r[15:8]});
      call(`CODE_COPY, 32'h81, 32'hc2, 32'hbeef_0000, 0);
      rd("empty copy", `OFF_RESULT, 32'h2000_0000);
      apb(0, `OFF_STATUS, 0);
      note("empty irq", 32'h2, {24'h0, r[15:8]});
      call(`CODE_COPY, 32'h81, 32'hc2, 32'h1, 32'h1);
      rd("bad copy", `OFF_RESULT, 32'h2000_0001);
      apb(0, `OFF_STATUS, 0);
      note("no irq", 32'h2, {24'h0, r[15:8]});
      $display("copies done");
      // Argument write during a running fill must be dropped
      apb(1, `OFF_ARG1, 32'h40);
      apb(1, `OFF_ARG2, 32'h8);
      apb(1, `OFF_CMD, {16'h0, `CODE_FILL});
      apb(1, `OFF_ARG0, 0);
      rd("busy status", `OFF_STATUS, 32'h0000_0203);
      wait_done();
      note("kept pattern", 32'h81, mem[16]);
      apb(1, `OFF_STATUS, 0);
      rd("status cleared", `OFF_STATUS, 32'h0000_0200);
      call(16'h1234, 0, 0, 0, 0);
      rd("unknown code", `OFF_RESULT, 32'h2000_0001);
      $display("busy refusal and unknown code done");
      apb(0, 8'h20, 0);
      note("unmapped", 32'h1, {31'h0, rerr});
      results();
   end
endmodule : hw_call_fill_and_buffer_copy_test
`default_nettype wire
